// ==== logic/sbd_core.sv ====
`timescale 1ns/1ps
`default_nettype none

module sbd_core (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic i_pin,
    output logic o_pin_out,
    output logic o_pin_oe,
    input wire logic i_special_single_chip,
    input wire logic i_insn_boundary,
    input wire logic i_tag_hit,
    input wire logic i_halt_instr,
    input wire logic i_fw_go,
    input wire logic i_bus_free,
    input wire logic [15:0] i_bus_rdata,
    output sbd_pkg::sbd_bus_t o_bus,
    output logic o_cpu_freeze,
    output logic o_cpu_resume,
    output logic o_bg_active,
    output logic o_dbg_map_active,
    output logic o_periph_suspend,
    output logic o_fw_enable
);

    ////////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic s1;
        logic in_bit;
        logic [3:0] cnt;
        logic tx_act;
        logic tx_bit;
        logic [9:0] idle;
        sbd_pkg::sbd_phase_t phase;
        logic [4:0] bits;
        logic [7:0] opc;
        logic [15:0] addr;
        logic [15:0] shf;
        logic pin_out;
        logic pin_oe;
        logic req;
        logic [7:0] wait_cnt;
        logic freeze;
        logic fw_en;
        logic bg_act;
        logic bg_pend;
        logic [3:0] rsm_cnt;
        logic resume;
        logic strap_done;
    } sbd_state_t;

    sbd_state_t r;
    sbd_state_t next_r;

    logic fall;
    logic sample;
    logic [15:0] shifted;
    logic [7:0] new_opc;
    logic opc_rw;
    logic internal_hit;
    logic bus_go;
    logic [15:0] rd_word;
    logic [15:0] int_word;
    logic [7:0] status_byte;

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    always_comb
    begin
        // pin is synchronous here, so one flop of history keeps the start latency within a cycle
        fall = r.s1 & ~i_pin;
        sample = r.in_bit && (r.cnt == sbd_pkg::RX_SAMPLE_CYC) && !fall;
        shifted = {r.shf[14:0], i_pin};
        new_opc = shifted[7:0];
        opc_rw = 1'b1;
        unique case (new_opc)
            sbd_pkg::OPC_READ_DEBUGMAP_BYTE, sbd_pkg::OPC_READ_DEBUGMAP_WORD,
            sbd_pkg::OPC_READ_BYTE, sbd_pkg::OPC_READ_WORD:
                opc_rw = 1'b1;
            sbd_pkg::OPC_WRITE_DEBUGMAP_BYTE, sbd_pkg::OPC_WRITE_DEBUGMAP_WORD,
            sbd_pkg::OPC_WRITE_BYTE, sbd_pkg::OPC_WRITE_WORD:
                opc_rw = 1'b1;
            default:
                opc_rw = 1'b0;
        endcase
        status_byte = 8'h00;
        status_byte[sbd_pkg::STAT_FW_ENABLE_BIT] = r.fw_en;
        status_byte[sbd_pkg::STAT_ACTIVE_BIT] = r.bg_act;
        // debug registers are served here; the ROM above them goes out on the bus
        internal_hit = r.opc[sbd_pkg::OPC_DBGMAP_BIT]
            && (r.addr >= sbd_pkg::ADDR_DBG_MAP_BASE)
            && (r.addr <= sbd_pkg::ADDR_DBG_REG_LAST);
        unique case ({r.addr[15:1], 1'b0})
            sbd_pkg::ADDR_DBG_INSTR:
                int_word = {r.opc, status_byte};
            sbd_pkg::ADDR_DBG_SHIFT:
                int_word = r.shf;
            sbd_pkg::ADDR_DBG_ADDRESS:
                int_word = r.addr;
            default:
                int_word = 16'h0000;
        endcase
        rd_word = internal_hit ? int_word : i_bus_rdata;
        if (!r.opc[sbd_pkg::OPC_WORD_BIT])
        begin
            rd_word = r.addr[0] ? {8'h00, rd_word[7:0]} : {rd_word[15:8], 8'h00};
        end
        bus_go = r.req && (i_bus_free || r.freeze);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        next_r = r;
        next_r.s1 = i_pin;
        next_r.resume = 1'b0;

        // bit timer restarts on each host falling edge
        if (fall)
        begin
            next_r.in_bit = 1'b1;
            next_r.cnt = 4'h0;
            next_r.tx_act = (r.phase == sbd_pkg::PH_RDATA);
            next_r.tx_bit = r.shf[15];
        end
        else if (r.in_bit)
        begin
            if (r.cnt == sbd_pkg::BIT_NOMINAL_CYC)
            begin
                next_r.in_bit = 1'b0;
                next_r.tx_act = 1'b0;
            end
            else
            begin
                next_r.cnt = r.cnt + 4'h1;
            end
        end

        // serial command sequencing
        if (sample)
        begin
            unique case (r.phase)
                sbd_pkg::PH_OPCODE:
                begin
                    next_r.shf = shifted;
                    next_r.bits = r.bits + 5'h01;
                    if (r.bits == sbd_pkg::OPCODE_BITS - 5'h01)
                    begin
                        next_r.bits = 5'h00;
                        next_r.opc = new_opc;
                        if (new_opc == sbd_pkg::OPC_ENTER_BACKGROUND && r.fw_en)
                        begin
                            next_r.bg_pend = 1'b1;
                        end
                        if (opc_rw)
                        begin
                            next_r.phase = sbd_pkg::PH_ADDRESS;
                        end
                    end
                end
                sbd_pkg::PH_ADDRESS:
                begin
                    next_r.shf = shifted;
                    next_r.bits = r.bits + 5'h01;
                    if (r.bits == sbd_pkg::WORD_BITS - 5'h01)
                    begin
                        next_r.bits = 5'h00;
                        next_r.addr = shifted;
                        // word accesses are forced onto an even address
                        if (r.opc[sbd_pkg::OPC_WORD_BIT])
                        begin
                            next_r.addr[0] = 1'b0;
                        end
                        if (r.opc[sbd_pkg::OPC_READ_BIT])
                        begin
                            next_r.phase = sbd_pkg::PH_ACCESS;
                            next_r.req = 1'b1;
                        end
                        else
                        begin
                            next_r.phase = sbd_pkg::PH_WDATA;
                        end
                    end
                end
                sbd_pkg::PH_WDATA:
                begin
                    next_r.shf = shifted;
                    next_r.bits = r.bits + 5'h01;
                    if (r.bits == sbd_pkg::WORD_BITS - 5'h01)
                    begin
                        next_r.bits = 5'h00;
                        next_r.phase = sbd_pkg::PH_ACCESS;
                        next_r.req = 1'b1;
                    end
                end
                sbd_pkg::PH_RDATA:
                begin
                    next_r.shf = {r.shf[14:0], 1'b0};
                    next_r.bits = r.bits + 5'h01;
                    if (r.bits == sbd_pkg::WORD_BITS - 5'h01)
                    begin
                        next_r.bits = 5'h00;
                        next_r.phase = sbd_pkg::PH_OPCODE;
                    end
                end
                sbd_pkg::PH_ACCESS:
                begin
                    // host edges during the access are ignored
                end
            endcase
        end

        // memory access: own registers at once, otherwise a free or stolen bus cycle
        if (r.phase == sbd_pkg::PH_ACCESS && (internal_hit || bus_go))
        begin
            next_r.req = 1'b0;
            next_r.freeze = 1'b0;
            next_r.wait_cnt = 8'h00;
            next_r.phase = r.opc[sbd_pkg::OPC_READ_BIT] ? sbd_pkg::PH_RDATA : sbd_pkg::PH_OPCODE;
            if (r.opc[sbd_pkg::OPC_READ_BIT])
            begin
                next_r.shf = rd_word;
            end
            else if (internal_hit && r.addr[15:1] == sbd_pkg::ADDR_DBG_STATUS[15:1])
            begin
                // status lives in the low byte of the even word
                next_r.fw_en = r.shf[sbd_pkg::STAT_FW_ENABLE_BIT];
            end
        end
        else if (r.req)
        begin
            next_r.wait_cnt = r.wait_cnt + 8'h01;
            if (r.wait_cnt == sbd_pkg::STEAL_WAIT_CYC)
            begin
                next_r.freeze = 1'b1;
            end
        end

        // inactivity time-out; an access still waiting is abandoned too
        if (fall)
        begin
            next_r.idle = 10'h000;
        end
        else if (r.idle == sbd_pkg::TIMEOUT_CYC)
        begin
            next_r.idle = 10'h000;
            next_r.phase = sbd_pkg::PH_OPCODE;
            next_r.bits = 5'h00;
            next_r.opc = 8'h00;
            next_r.req = 1'b0;
            next_r.freeze = 1'b0;
            next_r.wait_cnt = 8'h00;
        end
        else
        begin
            next_r.idle = r.idle + 10'h001;
        end

        // pin drive, computed ahead so the pin comes from a flop
        next_r.pin_oe = 1'b0;
        next_r.pin_out = 1'b0;
        if (next_r.tx_act)
        begin
            if (next_r.tx_bit)
            begin
                next_r.pin_oe = (next_r.cnt == sbd_pkg::TX_ONE_SPEEDUP_CYC);
                next_r.pin_out = 1'b1;
            end
            else
            begin
                next_r.pin_oe = (next_r.cnt <= sbd_pkg::TX_ZERO_LOW_CYC);
                next_r.pin_out = (next_r.cnt == sbd_pkg::TX_ZERO_LOW_CYC);
            end
        end

        // firmware exit goes first so that an activation in the same cycle still wins
        if (i_fw_go)
        begin
            next_r.bg_act = 1'b0;
        end
        // background activation
        if (r.bg_pend && i_insn_boundary)
        begin
            next_r.bg_pend = 1'b0;
            next_r.bg_act = 1'b1;
        end
        if (i_tag_hit || i_halt_instr)
        begin
            if (r.fw_en)
            begin
                next_r.bg_act = 1'b1;
            end
            else
            begin
                next_r.rsm_cnt = sbd_pkg::RESUME_DELAY_CYC;
            end
        end
        if (r.rsm_cnt != 4'h0)
        begin
            next_r.rsm_cnt = r.rsm_cnt - 4'h1;
            next_r.resume = (r.rsm_cnt == 4'h1);
        end
        // strap caught on the first clock after reset release
        if (!r.strap_done)
        begin
            next_r.strap_done = 1'b1;
            if (i_special_single_chip)
            begin
                next_r.fw_en = 1'b1;
                next_r.bg_act = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            r <= '0;
            r.s1 <= 1'b1;
            r.phase <= sbd_pkg::PH_OPCODE;
        end
        else
        begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign o_pin_out = r.pin_out;
    assign o_pin_oe = r.pin_oe;
    assign o_bus.req = r.req;
    assign o_bus.we = ~r.opc[sbd_pkg::OPC_READ_BIT];
    assign o_bus.byte_acc = ~r.opc[sbd_pkg::OPC_WORD_BIT];
    assign o_bus.dbgmap = r.opc[sbd_pkg::OPC_DBGMAP_BIT];
    assign o_bus.addr = r.addr;
    assign o_bus.wdata = r.shf;
    assign o_cpu_freeze = r.freeze;
    assign o_cpu_resume = r.resume;
    assign o_bg_active = r.bg_act;
    assign o_dbg_map_active = r.bg_act;
    assign o_periph_suspend = r.bg_act;
    assign o_fw_enable = r.fw_en;

endmodule : sbd_core

`default_nettype wire

// ==== logic/sbd_pkg.sv ====
package sbd_pkg;

    // hardware command opcodes
    localparam logic [7:0] OPC_ENTER_BACKGROUND = 8'h90;
    localparam logic [7:0] OPC_READ_DEBUGMAP_BYTE = 8'hE4;
    localparam logic [7:0] OPC_READ_DEBUGMAP_WORD = 8'hEC;
    localparam logic [7:0] OPC_READ_BYTE = 8'hE0;
    localparam logic [7:0] OPC_READ_WORD = 8'hE8;
    localparam logic [7:0] OPC_WRITE_DEBUGMAP_BYTE = 8'hC4;
    localparam logic [7:0] OPC_WRITE_DEBUGMAP_WORD = 8'hCC;
    localparam logic [7:0] OPC_WRITE_BYTE = 8'hC0;
    localparam logic [7:0] OPC_WRITE_WORD = 8'hC8;
    // opcode bit positions that select direction, debug map and word size
    localparam int OPC_DBGMAP_BIT = 2;
    localparam int OPC_WORD_BIT = 3;
    localparam int OPC_READ_BIT = 5;

    // debug map addresses
    localparam logic [15:0] ADDR_DBG_MAP_BASE = 16'hFF00;
    localparam logic [15:0] ADDR_DBG_REG_LAST = 16'hFF06;
    localparam logic [15:0] ADDR_DBG_INSTR = 16'hFF00;
    localparam logic [15:0] ADDR_DBG_STATUS = 16'hFF01;
    localparam logic [15:0] ADDR_DBG_SHIFT = 16'hFF02;
    localparam logic [15:0] ADDR_DBG_ADDRESS = 16'hFF04;
    localparam int STAT_FW_ENABLE_BIT = 7;
    localparam int STAT_ACTIVE_BIT = 6;

    // serial bit timing, in bus clock cycles from the perceived bit start
    localparam logic [3:0] BIT_NOMINAL_CYC = 4'hF;
    localparam logic [3:0] RX_SAMPLE_CYC = 4'hA;
    localparam logic [3:0] TX_ONE_SPEEDUP_CYC = 4'h7;
    localparam logic [3:0] TX_ZERO_LOW_CYC = 4'hD;
    localparam logic [9:0] TIMEOUT_CYC = 10'h200 - 10'h001;
    localparam logic [7:0] STEAL_WAIT_CYC = 8'h80 - 8'h01;
    localparam logic [3:0] RESUME_DELAY_CYC = 4'h4;
    localparam logic [4:0] OPCODE_BITS = 5'h08;
    localparam logic [4:0] WORD_BITS = 5'h10;

    typedef enum logic [2:0] {
        PH_OPCODE = 3'b000,
        PH_ADDRESS = 3'b001,
        PH_WDATA = 3'b010,
        PH_ACCESS = 3'b011,
        PH_RDATA = 3'b100
    } sbd_phase_t;

    typedef struct packed {
        logic req;
        logic we;
        logic byte_acc;
        logic dbgmap;
        logic [15:0] addr;
        logic [15:0] wdata;
    } sbd_bus_t;

endpackage : sbd_pkg

// ==== test/sbd_chk.sv ====
`timescale 1ns/1ps
`default_nettype none

module sbd_chk (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic i_tag_hit,
    input wire logic i_halt_instr,
    input wire logic i_bus_free,
    input wire logic o_pin_out,
    input wire logic o_pin_oe,
    input wire sbd_pkg::sbd_bus_t o_bus,
    input wire logic o_cpu_freeze,
    input wire logic o_cpu_resume,
    input wire logic o_bg_active,
    input wire logic o_dbg_map_active,
    input wire logic o_periph_suspend,
    input wire logic o_fw_enable
);

////////////////////////////////////////////////////////////////////////////////
    logic [7:0] st_cnt;
    logic [4:0] lo_cnt;
    logic act_req;

    assign act_req = i_halt_instr | i_tag_hit;

    // counters stand in for repetitions longer than the tools unroll cheaply
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            st_cnt <= 8'h00;
            lo_cnt <= 5'h00;
        end
        else
        begin
            st_cnt <= (o_bus.req && !i_bus_free && !o_cpu_freeze) ? st_cnt + 8'h01 : 8'h00;
            lo_cnt <= (o_pin_oe && !o_pin_out) ? lo_cnt + 5'h01 : 5'h00;
        end
    end

////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_reset_n);

    property p_frz_req; o_cpu_freeze |-> o_bus.req; endproperty
    property p_frz_drop; o_cpu_freeze |=> !o_cpu_freeze && !o_bus.req; endproperty
    property p_steal_bound; st_cnt <= 8'h80; endproperty
    property p_acc_once; o_bus.req && i_bus_free |=> !o_bus.req; endproperty
    property p_pulse_one; o_pin_oe && o_pin_out |=> !o_pin_oe; endproperty
    property p_zero_low; o_pin_oe && o_pin_out && $past(o_pin_oe) |-> lo_cnt == 5'h0D; endproperty
    property p_resume;
        $rose(o_cpu_resume) |-> !o_fw_enable && ($past(act_req, 4) || $past(act_req, 5)) ##1 !o_cpu_resume;
    endproperty
    property p_map; o_dbg_map_active == o_bg_active && o_periph_suspend == o_bg_active; endproperty
    property p_bg_gate; $rose(o_bg_active) |-> o_fw_enable; endproperty
    property p_tag; o_fw_enable && !o_bg_active && act_req |=> o_bg_active; endproperty

    a_frz_req: assert property (p_frz_req) else $error("freeze without request");
    a_frz_drop: assert property (p_frz_drop) else $error("freeze outlived access");
    a_steal_bound: assert property (p_steal_bound) else $error("steal came late");
    a_acc_once: assert property (p_acc_once) else $error("request held after access");
    a_pulse_one: assert property (p_pulse_one) else $error("speed-up pulse too long");
    a_zero_low: assert property (p_zero_low) else $error("zero low time wrong");
    a_resume: assert property (p_resume) else $error("resume pulse wrong");
    a_map: assert property (p_map) else $error("map or suspend mismatch");
    a_bg_gate: assert property (p_bg_gate) else $error("background without enable");
    a_tag: assert property (p_tag) else $error("tag or halt not taken");

    c_steal: cover property (o_cpu_freeze);
    c_zero: cover property (o_pin_oe && o_pin_out && $past(o_pin_oe));
    c_resume: cover property ($rose(o_cpu_resume));
    c_bg: cover property ($rose(o_bg_active));

endmodule : sbd_chk

`default_nettype wire

// ==== test/sbd_host.sv ====
`timescale 1ns/1ps
`default_nettype none

module sbd_host (
    input wire logic i_ref_clk,
    input wire logic i_pin,
    output logic o_low
);

    initial o_low = 1'b0;

    task automatic step(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask : step

    // 20-clock bit period leaves room for the device's late speed-up pulse
    task automatic bitx(input logic b);
        step(1);
        o_low = 1'b1;
        step(b ? 4 : 16);
        o_low = 1'b0;
        step(b ? 15 : 3);
    endtask : bitx

    task automatic tx8(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) bitx(v[i]);
    endtask : tx8

    task automatic tx16(input logic [15:0] v);
        for (int i = 15; i >= 0; i--) bitx(v[i]);
    endtask : tx16

    task automatic rx16(output logic [15:0] v);
        for (int i = 15; i >= 0; i--)
        begin
            step(1);
            o_low = 1'b1;
            step(3);
            o_low = 1'b0;
            step(7);
            v[i] = i_pin;
            step(9);
        end
    endtask : rx16

endmodule : sbd_host

`default_nettype wire

// ==== test/single_wire_background_debug_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fails++; \
    $display("[ERR] %0t got %h exp %h", $time, a, e); end end

module single_wire_background_debug_tb;

    logic clk, rst_n, strap, boundary, tag, halt, fw_go, bus_free, host_low;
    logic pin_out, pin_oe, frz, resume, bg, map, susp, fwen, acc_frz;
    logic [15:0] rdata;
    sbd_pkg::sbd_bus_t bus, acc;
    int acc_n = 0;
    int fails = 0;
    int n_tests = 0;
    wire logic pin;

    // pull-up: the wire is low only while someone drives it low
    assign pin = !(host_low || (pin_oe && !pin_out));

    sbd_core i_dut (
        .i_ref_clk(clk),
        .i_reset_n(rst_n),
        .i_pin(pin),
        .o_pin_out(pin_out),
        .o_pin_oe(pin_oe),
        .i_special_single_chip(strap),
        .i_insn_boundary(boundary),
        .i_tag_hit(tag),
        .i_halt_instr(halt),
        .i_fw_go(fw_go),
        .i_bus_free(bus_free),
        .i_bus_rdata(rdata),
        .o_bus(bus),
        .o_cpu_freeze(frz),
        .o_cpu_resume(resume),
        .o_bg_active(bg),
        .o_dbg_map_active(map),
        .o_periph_suspend(susp),
        .o_fw_enable(fwen)
    );

    sbd_host i_host (.i_ref_clk(clk), .i_pin(pin), .o_low(host_low));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk)
        if (bus.req && (bus_free || frz))
        begin
            acc <= bus;
            acc_frz <= frz;
            acc_n <= acc_n + 1;
        end

////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (fails == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic do_reset();
        rst_n = 1'b0;
        tick(4);
        rst_n = 1'b1;
    endtask : do_reset

    task automatic wr(input logic [7:0] op, input logic [15:0] a, input logic [15:0] d);
        int n0;
        n0 = acc_n;
        i_host.tx8(op);
        i_host.tx16(a);
        i_host.tx16(d);
        for (int i = 0; i < 400 && acc_n == n0; i++) tick(1);
        if (acc_n == n0)
        begin
            fails++;
            give_verdict();
        end
        tick(150);
    endtask : wr

    task automatic rd(input logic [7:0] op, input logic [15:0] a, output logic [15:0] d);
        i_host.tx8(op);
        i_host.tx16(a);
        tick(150);
        i_host.rx16(d);
    endtask : rd

////////////////////////////////////////////////////////////////////////////////
    task automatic t_write();
        wr(sbd_pkg::OPC_WRITE_BYTE, 16'h1235, 16'h00A5);
        `CHK(acc.we, 1'b1)
        `CHK(acc.addr, 16'h1235)
        `CHK(acc.wdata, 16'h00A5)
        `CHK({acc.byte_acc, acc.dbgmap}, 2'b10)
        `CHK(acc_frz, 1'b0)
    endtask : t_write

    task automatic t_steal();
        bus_free = 1'b0;
        wr(sbd_pkg::OPC_WRITE_WORD, 16'h2001, 16'hBEEF);
        `CHK(acc_frz, 1'b1)
        `CHK(acc.addr, 16'h2000)
        `CHK(acc.byte_acc, 1'b0)
        bus_free = 1'b1;
    endtask : t_steal

    task automatic t_read();
        logic [7:0] ops[3] = '{8'hE0, 8'hE8, 8'hE0};
        logic [15:0] adr[3] = '{16'h0101, 16'h0100, 16'h0100};
        logic [15:0] exp[3] = '{16'h0034, 16'h1234, 16'h1200};
        logic [15:0] d;
        rdata = 16'h1234;
        for (int i = 0; i < 3; i++)
        begin
            rd(ops[i], adr[i], d);
            `CHK(d, exp[i])
        end
        `CHK({acc.we, acc.dbgmap}, 2'b00)
    endtask : t_read

    task automatic t_refuse();
        logic seen;
        seen = 1'b0;
        halt = 1'b1;
        tick(1);
        halt = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            seen = seen | resume;
            tick(1);
        end
        `CHK(seen, 1'b1)
        `CHK(bg, 1'b0)
    endtask : t_refuse

    task automatic t_enable();
        logic [15:0] d;
        wr(sbd_pkg::OPC_WRITE_DEBUGMAP_BYTE, sbd_pkg::ADDR_DBG_STATUS, 16'h0080);
        `CHK(fwen, 1'b1)
        `CHK(acc.dbgmap, 1'b1)
        rd(sbd_pkg::OPC_READ_DEBUGMAP_BYTE, sbd_pkg::ADDR_DBG_STATUS, d);
        `CHK(d, 16'h0080)
        wr(sbd_pkg::OPC_WRITE_DEBUGMAP_WORD, sbd_pkg::ADDR_DBG_INSTR, 16'h0000);
        `CHK({fwen, acc.byte_acc}, 2'b00)
        wr(sbd_pkg::OPC_WRITE_DEBUGMAP_BYTE, sbd_pkg::ADDR_DBG_STATUS, 16'h0080);
        rd(sbd_pkg::OPC_READ_DEBUGMAP_WORD, sbd_pkg::ADDR_DBG_INSTR, d);
        `CHK(d, 16'hEC80)
    endtask : t_enable

    task automatic t_bg();
        i_host.tx8(sbd_pkg::OPC_ENTER_BACKGROUND);
        tick(40);
        `CHK(bg, 1'b0)
        boundary = 1'b1;
        tick(1);
        boundary = 1'b0;
        tick(1);
        `CHK({bg, map, susp}, 3'b111)
        fw_go = 1'b1;
        tick(1);
        fw_go = 1'b0;
        tick(1);
        `CHK({bg, susp}, 2'b00)
        tag = 1'b1;
        tick(1);
        tag = 1'b0;
        tick(1);
        `CHK(bg, 1'b1)
        fw_go = 1'b1;
        tick(1);
        {fw_go, halt} = 2'b01;
        tick(1);
        halt = 1'b0;
        tick(1);
        `CHK(bg, 1'b1)
    endtask : t_bg

    task automatic t_timeout();
        for (int i = 0; i < 4; i++) i_host.bitx(1'b1);
        tick(600);
        wr(sbd_pkg::OPC_WRITE_BYTE, 16'h0042, 16'h0011);
        `CHK(acc.addr, 16'h0042)
    endtask : t_timeout

    task automatic t_special();
        strap = 1'b1;
        do_reset();
        tick(1);
        `CHK({fwen, bg}, 2'b11)
    endtask : t_special

////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rst_n = 1'b0;
        {strap, boundary, tag, halt, fw_go} = 5'h00;
        bus_free = 1'b1;
        rdata = 16'h0000;
        tick(4);
        rst_n = 1'b1;
        t_write();
        t_steal();
        t_read();
        t_refuse();
        t_timeout();
        t_enable();
        t_bg();
        t_special();
        give_verdict();
    end

endmodule : single_wire_background_debug_tb

bind sbd_core sbd_chk i_chk (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_tag_hit(i_tag_hit),
    .i_halt_instr(i_halt_instr), .i_bus_free(i_bus_free), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
    .o_bus(o_bus), .o_cpu_freeze(o_cpu_freeze), .o_cpu_resume(o_cpu_resume), .o_bg_active(o_bg_active),
    .o_dbg_map_active(o_dbg_map_active), .o_periph_suspend(o_periph_suspend), .o_fw_enable(o_fw_enable));

`default_nettype wire
